// File: logic/adcpd_top.sv
// converter digital side: sleep control, conversion pipeline and parallel output port
//
// Overview of operation
// - high sleep request holds idle; low leaves
// - idle data outputs carry a fixed junk word
// - entering idle destroys words in pipeline
// - valid words only with hold-off, sleep low
// - hold-off high floats all data outputs
// - conversion continues regardless of hold-off
`default_nettype none
module adcpd_top
  import adcpd_pkg::*;
#(
  parameter int DATA_W = ADCPD_DATA_W,
  parameter int PIPE_DEPTH = ADCPD_PIPE_DEPTH,
  parameter int FIFO_DEPTH = ADCPD_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sleep_request_in,
  input wire logic out_hold_off_in,
  input wire logic [DATA_W-1:0] sample_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe_n_out,
  output logic sleeping_out
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != ADCPD_DATA_W) begin : g_bad_width
    $error("data width must match the twelve bit output port");
  end
  if (PIPE_DEPTH < 1) begin : g_bad_pipe
    $error("pipeline depth must be at least 1");
  end
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
    $error("fifo depth must be a power of two of at least 2");
  end
  if (ADCPD_SYNC_STAGES != 3) begin : g_bad_sync
    $error("pin synchronisers are built for three stages");
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [ADCPD_SYNC_STAGES-1:0] sleep_sync_q;
  logic [ADCPD_SYNC_STAGES-1:0] hold_sync_q;
  logic sleep_lvl_q;
  logic hold_lvl_q;

  // three stages so a metastable first stage never reaches the state machine
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sleep_sync_q <= '0;
    end else begin
      sleep_sync_q <= {sleep_sync_q[ADCPD_SYNC_STAGES-2:0], sleep_request_in};
    end
  end

  // hold-off resets high so the pins float until the pin is seen low
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_sync_q <= '1;
    end else begin
      hold_sync_q <= {hold_sync_q[ADCPD_SYNC_STAGES-2:0], out_hold_off_in};
    end
  end

  // ----------------------------------------------------------------
  // pin level filters
  // ----------------------------------------------------------------
  // a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sleep_lvl_q <= 1'b0;
    end else if (sleep_sync_q[ADCPD_SYNC_STAGES-2] == sleep_sync_q[ADCPD_SYNC_STAGES-1]) begin
      sleep_lvl_q <= sleep_sync_q[ADCPD_SYNC_STAGES-1];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_lvl_q <= 1'b1;
    end else if (hold_sync_q[ADCPD_SYNC_STAGES-2] == hold_sync_q[ADCPD_SYNC_STAGES-1]) begin
      hold_lvl_q <= hold_sync_q[ADCPD_SYNC_STAGES-1];
    end
  end

  // ----------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------
  adcpd_state_type state_q;
  adcpd_state_type state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ADCPD_ST_RUN: begin
        if (sleep_lvl_q) begin
          state_d = ADCPD_ST_SLEEP;
        end
      end
      ADCPD_ST_SLEEP: begin
        if (!sleep_lvl_q) begin
          state_d = ADCPD_ST_RUN;
        end
      end
      default: begin
        state_d = ADCPD_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ADCPD_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // conversion stops and the fifo is flushed while this is high
  logic asleep;
  assign asleep = (state_q == ADCPD_ST_SLEEP);

  // ----------------------------------------------------------------
  // conversion pipeline
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] pipe_q [PIPE_DEPTH];
  logic pipe_stall;

  generate
    for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_pipe
      logic [DATA_W-1:0] stage_src;
      if (i == 0) begin : g_head
        assign stage_src = sample_in;
      end else begin : g_link
        assign stage_src = pipe_q[i-1];
      end
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pipe_q[i] <= ADCPD_DATA_RST;
        end else if (asleep) begin
          pipe_q[i] <= ADCPD_JUNK_WORD ^ DATA_W'(i);
        end else if (!pipe_stall) begin
          pipe_q[i] <= stage_src;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // output fifo
  // ----------------------------------------------------------------
  adcpd_fifo_if #(.WIDTH(DATA_W)) wr_if ();
  adcpd_fifo_if #(.WIDTH(DATA_W)) rd_if ();

  assign wr_if.valid = !asleep;
  assign wr_if.data = pipe_q[PIPE_DEPTH-1];
  // full fifo stalls the pipeline rather than dropping words
  assign pipe_stall = !wr_if.ready;
  assign rd_if.ready = 1'b1;

  // flushing while idle keeps words from before idle off the port

  adcpd_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .flush_in(asleep),
    .wr(wr_if.snk),
    .rd(rd_if.src)
  );

  // ----------------------------------------------------------------
  // output port registers
  // ----------------------------------------------------------------
  // the last word stands when the fifo runs dry
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= ADCPD_DATA_RST;
    end else if (asleep) begin
      data_out <= ADCPD_JUNK_WORD;
    end else if (rd_if.valid) begin
      data_out <= rd_if.data;
    end
  end

  // ----------------------------------------------------------------
  // output enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_oe_n_out <= '1;
    end else begin
      data_oe_n_out <= {DATA_W{hold_lvl_q}};
    end
  end

  // ----------------------------------------------------------------
  // idle flag
  // ----------------------------------------------------------------
  // taken from the next state so the flag moves with the state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sleeping_out <= 1'b0;
    end else begin
      sleeping_out <= (state_d == ADCPD_ST_SLEEP);
    end
  end
endmodule : adcpd_top
`default_nettype wire

// File: logic/adcpd_pkg.sv
// shared constants and types for the converter output port block
`default_nettype none
package adcpd_pkg;
  localparam int ADCPD_DATA_W = 12;
  localparam int ADCPD_PIPE_DEPTH = 6;
  localparam int ADCPD_FIFO_DEPTH = 8;
  localparam int ADCPD_SYNC_STAGES = 3;
  localparam logic [11:0] ADCPD_DATA_RST = 12'h000;
  localparam logic [11:0] ADCPD_JUNK_WORD = 12'ha5a;

  typedef enum logic [1:0] {
    ADCPD_ST_RUN = 2'b01,
    ADCPD_ST_SLEEP = 2'b10
  } adcpd_state_type;
endpackage : adcpd_pkg
`default_nettype wire

// File: logic/adcpd_fifo_if.sv
// valid/ready stream carrier between the converter core and its output fifo
`default_nettype none
interface adcpd_fifo_if #(
  parameter int WIDTH = 12
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : adcpd_fifo_if
`default_nettype wire

// File: logic/adcpd_fifo.sv
// parameterised synchronous fifo with valid and ready on both sides
`default_nettype none
module adcpd_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  adcpd_fifo_if.snk wr,
  adcpd_fifo_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  logic full;
  logic empty;

  assign full = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
  assign empty = (wptr_q == rptr_q);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (wr.valid && !full) begin
      mem_q[wptr_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else if (flush_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (wr.valid && !full) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (rd.ready && !empty) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end
endmodule : adcpd_fifo
`default_nettype wire

// File: tb/adcpd_top_chk.sv
// assertion checker for the converter output port
`default_nettype none
module adcpd_top_chk
  import adcpd_pkg::*;
#(
  parameter int PIPE_DEPTH = ADCPD_PIPE_DEPTH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sleep_request_in,
  input wire logic out_hold_off_in,
  input wire logic [11:0] sample_in,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe_n_out,
  input wire logic sleeping_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [3:0] run_q;
  // cycles awake, saturating
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) run_q <= 4'h0;
    else if (sleeping_out) run_q <= 4'h0;
    else if (run_q != 4'hf) run_q <= run_q + 4'h1;
  end
  sequence s_asleep;
    sleep_request_in [*7];
  endsequence
  chk_sleep_enter: assert property (s_asleep |-> sleeping_out) else $error("idle not entered");
  chk_sleep_leave: assert property (!sleep_request_in [*7] |-> !sleeping_out) else $error("idle not left");
  chk_idle_junk: assert property (sleeping_out [*2] |-> data_out == ADCPD_JUNK_WORD) else $error("idle word");
  chk_float_all: assert property (out_hold_off_in [*7] |-> &data_oe_n_out) else $error("pins not floating");
  chk_drive_all: assert property (!out_hold_off_in [*7] |-> data_oe_n_out == 12'h000) else $error("not driven");
  chk_word_delay: assert property (run_q == 4'hf |-> data_out == $past(sample_in, PIPE_DEPTH + 2))
    else $error("word delay");
endmodule : adcpd_top_chk
bind adcpd_top adcpd_top_chk #(.PIPE_DEPTH(PIPE_DEPTH)) i_adcpd_top_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .sleep_request_in(sleep_request_in), .out_hold_off_in(out_hold_off_in), .sample_in(sample_in),
  .data_out(data_out), .data_oe_n_out(data_oe_n_out), .sleeping_out(sleeping_out));
`default_nettype wire

// File: tb/adcpd_capture.sv
// receiving logic model latching words on the falling clock edge
`default_nettype none
module adcpd_capture (
  input wire logic clk_in,
  input wire logic [11:0] data_in,
  input wire logic [11:0] data_oe_n_in,
  output logic [11:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // one load per pin, falling edge latch
  always @(negedge clk_in) begin
    if (data_oe_n_in == 12'h000) word_out <= data_in;
  end
endmodule : adcpd_capture
`default_nettype wire

// File: tb/adcpd_top_tb_top.sv
// testbench top for the converter output port
`default_nettype none
module adcpd_top_tb_top;
  import adcpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sleep_request_in = 1'b0;
  logic out_hold_off_in = 1'b1;
  logic [11:0] sample_in = 12'h000;
  logic [11:0] cyc = 12'h000;
  logic [11:0] data_out;
  logic [11:0] data_oe_n_out;
  logic [11:0] cap_word;
  logic sleeping_out;
  int miscompares = 0;
  int comparisons = 0;
  adcpd_top i_adcpd_top (.clk_in(clk_in), .nrst_in(nrst_in), .sleep_request_in(sleep_request_in),
    .out_hold_off_in(out_hold_off_in), .sample_in(sample_in), .data_out(data_out),
    .data_oe_n_out(data_oe_n_out), .sleeping_out(sleeping_out));
  adcpd_capture i_adcpd_capture (.clk_in(clk_in), .data_in(data_out), .data_oe_n_in(data_oe_n_out),
    .word_out(cap_word));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 12'h001;
    sample_in <= cyc;
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic t_stream();
    @(posedge clk_in) out_hold_off_in <= 1'b0;
    step(20);
    repeat (4) begin
      check(cap_word, cyc - 12'h00a);
      check(data_oe_n_out, 12'h000);
      step(1);
    end
    $display("stream done");
  endtask : t_stream
  task automatic t_hold();
    @(posedge clk_in) out_hold_off_in <= 1'b1;
    step(10);
    check(data_oe_n_out, 12'hfff);
    check(data_out, cyc - 12'h009);
    @(posedge clk_in) out_hold_off_in <= 1'b0;
    step(10);
    check(data_oe_n_out, 12'h000);
    $display("hold-off done");
  endtask : t_hold
  task automatic t_sleep();
    logic [11:0] mark;
    @(posedge clk_in) sleep_request_in <= 1'b1;
    mark = cyc;
    step(10);
    check({11'h000, sleeping_out}, 12'h001);
    check(data_out, ADCPD_JUNK_WORD);
    @(posedge clk_in) sleep_request_in <= 1'b0;
    step(8);
    check({11'h000, sleeping_out}, 12'h000);
    repeat (10) begin
      comparisons++;
      if (data_out <= mark) begin
        miscompares++;
        $display("Error %0t: stale word %h", $time, data_out);
      end
      step(1);
    end
    check(cap_word, cyc - 12'h00a);
    $display("sleep done");
  endtask : t_sleep
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_stream();
    t_hold();
    t_sleep();
    complete_run();
  end
endmodule : adcpd_top_tb_top
`default_nettype wire
